//--- verilog/tpg_gpio.v
// two-port gpio: registers on avalon-mm, pad control, alternate functions
// Function
// R1: after reset all pins are inputs and alternate functions are off
// R2: direction bit 0 makes the pin input, 1 makes it output
// R3: float bit 1 forces a floating input with no pull
// R4: non-floating input pulls low on latch 0, high on latch 1
// R5: non-floating output drives the latch value
// R6: reading pin-value returns the synchronised pad level
// R7: writing pin-value stores into the port output latch
// R8: software should change latch bits singly to avoid upsetting others
// R9: port a has 8 pins, each also an analog input of same index
// R10: port b has 7 pins; bit 2 reserved in every port b register
// R11: b0 feeds eight_bit_timer capture/event, b1 feeds sixteen_bit_timer
// R12: b3 carries timer compare/pwm out; b4,b5 are interrupt inputs 0,1
// R13: b6 carries buzzer output, b7 is converter top reference
// R14: slow edge enable delays falling edges on b6,b7 by 250ns
// R15: software writes slew register twice; only bit 0 exists
// R16: reserved port b bit 2 reads zero and ignores writes
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "tpgpio_regs.vh"
module tpg_gpio #(
  parameter FALL_CYCLES = `TPG_FALL_DELAY_CYC
)
(
  input wire REF_CLK,
  input wire RST,
  input wire [8:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire [7:0] PA_IN,
  output wire [7:0] PA_OUT,
  output wire [7:0] PA_OE_N,
  output wire [7:0] PA_PULL_HIGH,
  output wire [7:0] PA_PULL_LOW,
  input wire [7:0] PA_ANALOG_SEL,
  input wire [7:0] PB_IN,
  output wire [7:0] PB_OUT,
  output wire [7:0] PB_OE_N,
  output wire [7:0] PB_PULL_HIGH,
  output wire [7:0] PB_PULL_LOW,
  input wire PB_ALT_COMPARE_EN,
  input wire PB_ALT_COMPARE,
  input wire PB_ALT_BUZZER_EN,
  input wire PB_ALT_BUZZER,
  output reg EIGHT_BIT_TIMER_IN,
  output reg SIXTEEN_BIT_TIMER_IN,
  output reg EXT_INT0,
  output reg EXT_INT1
);
  reg [7:0] a_lat;
  reg [7:0] a_dir;
  reg [7:0] a_flt;
  reg [7:0] b_lat;
  reg [7:0] b_dir;
  reg [7:0] b_flt;
  reg slow_edge_enable;
  reg [7:0] a_sync1;
  reg [7:0] a_sync2;
  reg [7:0] b_sync1;
  reg [7:0] b_sync2;
  reg ack;
  wire [6:0] idx;
  wire wr_ok;
  wire [7:0] wbyte;
  wire wr_a_lat;
  wire wr_a_dir;
  wire wr_a_flt;
  wire wr_b_lat;
  wire wr_b_dir;
  wire wr_b_flt;
  wire wr_slew;
  wire [7:0] a_oe;
  wire b6_delayed;
  wire b7_delayed;
  reg [7:0] next_rdata;
  reg [7:0] b_drive;
  reg [7:0] b_oe;

  // a pin drives only as an output, not floating, not given to another use
  function [7:0] drive_mask;
    input [7:0] dir;
    input [7:0] flt;
    input [7:0] keep;
    begin
      drive_mask = dir & ~flt & keep;
    end
  endfunction

  // an undriven, non-floating pin pulls towards its latch value
  function [7:0] pull_high_mask;
    input [7:0] oe;
    input [7:0] flt;
    input [7:0] lat;
    input [7:0] keep;
    begin
      pull_high_mask = ~oe & ~flt & lat & keep;
    end
  endfunction

  function [7:0] pull_low_mask;
    input [7:0] oe;
    input [7:0] flt;
    input [7:0] lat;
    input [7:0] keep;
    begin
      pull_low_mask = ~oe & ~flt & ~lat & keep;
    end
  endfunction

  // port b bit 2 has no pin, so it never holds a one
  function [7:0] b_legal;
    input [7:0] v;
    begin
      b_legal = v & `TPG_B_MASK;
    end
  endfunction

  // single wait state: every access finishes on the second edge
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;
  assign idx = AVS_ADDRESS[8:2];
  assign wr_ok = AVS_WRITE & ack & AVS_BYTEENABLE[0];
  assign wbyte = AVS_WRITEDATA[7:0];
  assign wr_a_lat = wr_ok & ((idx == `TPG_IDX_A_PIN) | (idx == `TPG_IDX_A_LAT)); // [R7]
  assign wr_a_dir = wr_ok & (idx == `TPG_IDX_A_DIR);
  assign wr_a_flt = wr_ok & (idx == `TPG_IDX_A_FLT);
  assign wr_b_lat = wr_ok & ((idx == `TPG_IDX_B_PIN) | (idx == `TPG_IDX_B_LAT)); // [R7]
  assign wr_b_dir = wr_ok & (idx == `TPG_IDX_B_DIR);
  assign wr_b_flt = wr_ok & (idx == `TPG_IDX_B_FLT);
  assign wr_slew = wr_ok & (idx == `TPG_IDX_SLEW);

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      ack <= 1'b0;
    else
      ack <= (AVS_READ | AVS_WRITE) & ~ack;
  end

  // pads are asynchronous to REF_CLK
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      a_sync1 <= 8'h00;
      a_sync2 <= 8'h00;
    end
    else
    begin
      a_sync1 <= PA_IN;
      a_sync2 <= a_sync1;
    end
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      b_sync1 <= 8'h00;
      b_sync2 <= 8'h00;
    end
    else
    begin
      b_sync1 <= PB_IN;
      b_sync2 <= b_sync1;
    end
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      a_lat <= `TPG_RST_BYTE; // [R1]
    else if (wr_a_lat)
      a_lat <= wbyte; // [R7]
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      a_dir <= `TPG_RST_BYTE; // [R1]
    else if (wr_a_dir)
      a_dir <= wbyte; // [R2]
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      a_flt <= `TPG_RST_BYTE;
    else if (wr_a_flt)
      a_flt <= wbyte; // [R3]
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      b_lat <= `TPG_RST_BYTE;
    else if (wr_b_lat)
      b_lat <= b_legal(wbyte); // [R7] [R16]
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      b_dir <= `TPG_RST_BYTE;
    else if (wr_b_dir)
      b_dir <= b_legal(wbyte); // [R10]
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      b_flt <= `TPG_RST_BYTE;
    else if (wr_b_flt)
      b_flt <= b_legal(wbyte); // [R16]
  end

  // each write stores; a repeated write leaves the same value
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      slow_edge_enable <= 1'b0;
    else if (wr_slew)
      slow_edge_enable <= wbyte[`TPG_SLEW_BIT]; // [R15]
  end

  always @*
  begin
    case (idx)
      `TPG_IDX_A_PIN: next_rdata = a_sync2; // [R6]
      `TPG_IDX_B_PIN: next_rdata = b_legal(b_sync2); // [R6] [R16]
      `TPG_IDX_A_DIR: next_rdata = a_dir;
      `TPG_IDX_B_DIR: next_rdata = b_dir;
      `TPG_IDX_A_FLT: next_rdata = a_flt;
      `TPG_IDX_B_FLT: next_rdata = b_flt;
      `TPG_IDX_SLEW: next_rdata = {7'h00, slow_edge_enable};
      `TPG_IDX_A_LAT: next_rdata = a_lat;
      `TPG_IDX_B_LAT: next_rdata = b_lat;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      AVS_READDATA <= 32'h0000_0000;
    else if (AVS_READ & ~ack)
      AVS_READDATA <= {24'h000000, next_rdata};
  end

  // port a: analog select tristates the digital pad and pulls
  assign a_oe = drive_mask(a_dir, a_flt, ~PA_ANALOG_SEL); // [R2] [R3] [R9]
  assign PA_OUT = a_lat; // [R5]
  assign PA_OE_N = ~a_oe;
  assign PA_PULL_HIGH = pull_high_mask(a_oe, a_flt, a_lat, ~PA_ANALOG_SEL); // [R4]
  assign PA_PULL_LOW = pull_low_mask(a_oe, a_flt, a_lat, ~PA_ANALOG_SEL); // [R4]

  // alternate outputs only take the pad when their enables are raised
  always @*
  begin
    b_drive = b_lat;
    b_oe = drive_mask(b_dir, b_flt, `TPG_B_MASK); // [R2] [R3] [R10]
    if (PB_ALT_COMPARE_EN)
    begin
      b_drive[3] = PB_ALT_COMPARE; // [R12]
      b_oe[3] = 1'b1;
    end
    if (PB_ALT_BUZZER_EN)
    begin
      b_drive[6] = PB_ALT_BUZZER; // [R13]
      b_oe[6] = 1'b1;
    end
  end

  tpg_fall_delay #(.CYCLES(FALL_CYCLES)) u_fall6 (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .enable(slow_edge_enable),
    .din(b_drive[6]),
    .dout(b6_delayed)
  ); // [R14]

  tpg_fall_delay #(.CYCLES(FALL_CYCLES)) u_fall7 (
    .REF_CLK(REF_CLK),
    .RST(RST),
    .enable(slow_edge_enable),
    .din(b_drive[7]),
    .dout(b7_delayed)
  ); // [R14]

  // b7 is also the converter reference: software keeps it floating for that
  assign PB_OUT = {b7_delayed, b6_delayed, b_drive[5:3], 1'b0, b_drive[1:0]}; // [R5] [R14]
  assign PB_OE_N = ~b_oe;
  assign PB_PULL_HIGH = pull_high_mask(b_oe, b_flt, b_lat, `TPG_B_MASK); // [R4]
  assign PB_PULL_LOW = pull_low_mask(b_oe, b_flt, b_lat, `TPG_B_MASK); // [R4]

  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      EIGHT_BIT_TIMER_IN <= 1'b0;
      SIXTEEN_BIT_TIMER_IN <= 1'b0;
      EXT_INT0 <= 1'b0;
      EXT_INT1 <= 1'b0;
    end
    else
    begin
      EIGHT_BIT_TIMER_IN <= b_sync2[0]; // [R11]
      SIXTEEN_BIT_TIMER_IN <= b_sync2[1]; // [R11]
      EXT_INT0 <= b_sync2[4]; // [R12]
      EXT_INT1 <= b_sync2[5]; // [R12]
    end
  end
endmodule
`default_nettype wire

//--- verilog/tpgpio_regs.vh
// register offsets, field positions, reset values and timing for the two-port gpio
`ifndef TPGPIO_REGS_VH
`define TPGPIO_REGS_VH
`define TPG_IDX_A_PIN 7'h00
`define TPG_IDX_B_PIN 7'h01
`define TPG_IDX_A_DIR 7'h04
`define TPG_IDX_B_DIR 7'h05
`define TPG_IDX_A_FLT 7'h08
`define TPG_IDX_B_FLT 7'h09
`define TPG_IDX_SLEW 7'h35
`define TPG_IDX_A_LAT 7'h59
`define TPG_IDX_B_LAT 7'h5a
`define TPG_RST_BYTE 8'h00
`define TPG_B_MASK 8'hfb
`define TPG_SLEW_BIT 0
`define TPG_FALL_DELAY_NS 250
`define TPG_CLK_MHZ 40
`define TPG_FALL_DELAY_CYC ((`TPG_FALL_DELAY_NS * `TPG_CLK_MHZ) / 1000)
`endif

//--- verilog/tpg_fall_delay.v
// falling-edge delay for one output pin, used for slow-edge mode
`timescale 1ns/10ps
`default_nettype none
module tpg_fall_delay #(
  parameter CYCLES = 10
)
(
  input wire REF_CLK,
  input wire RST,
  input wire enable,
  input wire din,
  output reg dout
);
  reg [7:0] count;

  // rising edges pass at once; a fall waits out the count
  always @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      dout <= 1'b0;
      count <= 8'h00;
    end
    else if (din || !enable)
    begin
      dout <= din;
      count <= 8'h00;
    end
    else if (dout)
    begin
      if (count >= CYCLES[7:0] - 8'h01)
      begin
        dout <= 1'b0;
        count <= 8'h00;
      end
      else
        count <= count + 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- test/tpg_chk_checker.sv
// checker: bus wait state, pad control and alternate input timing
`timescale 1ns/10ps
`default_nettype none
module tpg_chk(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic AVS_READ,
  input wire logic AVS_WAITREQUEST,
  input wire logic EIGHT_BIT_TIMER_IN,
  input wire logic SIXTEEN_BIT_TIMER_IN,
  input wire logic EXT_INT0,
  input wire logic EXT_INT1,
  input wire logic [7:0] PA_OE_N,
  input wire logic [7:0] PB_IN,
  input wire logic [7:0] PB_OUT,
  input wire logic [7:0] PB_OE_N,
  input wire logic [7:0] PB_PULL_HIGH,
  input wire logic [7:0] PB_PULL_LOW
);
  logic [1:0] age;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // pad history from before reset is not comparable
  always @(posedge REF_CLK or posedge RST)
    if (RST)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  sequence s_held;
    AVS_READ && AVS_WAITREQUEST;
  endsequence
  a_req_waits: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST) else $error("no wait state");
  a_wait_one: assert property (s_held |=> !AVS_WAITREQUEST) else $error("wait too long");
  a_rst_inputs: assert property ($fell(RST) |-> (PA_OE_N & PB_OE_N) == 8'hff) else $error("pin driven");
  a_pull_excl: assert property ((PB_PULL_HIGH & PB_PULL_LOW) == 8'h00) else $error("both pulls");
  a_drive_nopull: assert property ((~PB_OE_N & (PB_PULL_HIGH | PB_PULL_LOW)) == 8'h00) else $error("pull");
  a_rsvd_quiet: assert property (PB_OE_N[2] && !PB_OUT[2] && !PB_PULL_HIGH[2] && !PB_PULL_LOW[2])
    else $error("bit 2 active");
  a_tmr0_lag: assert property (age == 2'h3 |-> EIGHT_BIT_TIMER_IN == $past(PB_IN[0], 3)) else $error("t0");
  a_tmr1_lag: assert property (age == 2'h3 |-> SIXTEEN_BIT_TIMER_IN == $past(PB_IN[1], 3)) else $error("t1");
  a_int_lag: assert property (age == 2'h3 |-> {EXT_INT1, EXT_INT0} == $past(PB_IN[5:4], 3)) else $error("int");
endmodule
bind tpg_gpio tpg_chk tpg_chk_inst(.REF_CLK, .RST, .AVS_READ, .AVS_WAITREQUEST, .EIGHT_BIT_TIMER_IN,
  .SIXTEEN_BIT_TIMER_IN, .EXT_INT0, .EXT_INT1, .PA_OE_N, .PB_IN, .PB_OUT, .PB_OE_N, .PB_PULL_HIGH, .PB_PULL_LOW);
`default_nettype wire

//--- test/tpg_pad.sv
// pad model: level on every pin of both ports
`timescale 1ns/10ps
`default_nettype none
module tpg_pad(
  input wire logic clk,
  input wire logic [15:0] dout,
  input wire logic [15:0] oe_n,
  input wire logic [15:0] ph,
  input wire logic [15:0] pl,
  input wire logic [15:0] ext,
  input wire logic [15:0] ext_en,
  output logic [15:0] pad
);
  logic [15:0] tog = 16'h0000;
  // an undriven pin without pull wanders
  always @(posedge clk)
    tog <= ~tog;
  always_comb
    for (int i = 0; i < 16; i++)
      pad[i] = !oe_n[i] ? dout[i] : ext_en[i] ? ext[i] : ph[i] | (!pl[i] & tog[i]);
endmodule
`default_nettype wire

//--- test/tpg_gpio_tb.sv
// testbench for the two-port gpio
`timescale 1ns/10ps
`default_nettype none
`include "tpgpio_regs.vh"
module tpg_gpio_tb;
  logic REF_CLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [8:0] AVS_ADDRESS = 9'h000;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_WRITEDATA = 32'h0, rd;
  logic [15:0] e = 16'h0000, ee = 16'h0000;
  logic [7:0] PA_ANALOG_SEL = 8'h00;
  logic PB_ALT_COMPARE_EN = 1'b0, PB_ALT_COMPARE = 1'b0, PB_ALT_BUZZER_EN = 1'b0, PB_ALT_BUZZER = 1'b0;
  wire logic [31:0] AVS_READDATA;
  wire logic AVS_WAITREQUEST, EIGHT_BIT_TIMER_IN, SIXTEEN_BIT_TIMER_IN, EXT_INT0, EXT_INT1;
  wire logic [7:0] PA_IN, PA_OUT, PA_OE_N, PA_PULL_HIGH, PA_PULL_LOW, PB_IN, PB_OUT, PB_OE_N, PB_PULL_HIGH, PB_PULL_LOW;
  int err_count = 0;
  int compares = 0;
  tpg_gpio tpg_gpio_inst(.REF_CLK, .RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
    .AVS_READDATA, .AVS_WAITREQUEST, .PA_IN, .PA_OUT, .PA_OE_N, .PA_PULL_HIGH, .PA_PULL_LOW, .PA_ANALOG_SEL,
    .PB_IN, .PB_OUT, .PB_OE_N, .PB_PULL_HIGH, .PB_PULL_LOW, .PB_ALT_COMPARE_EN, .PB_ALT_COMPARE,
    .PB_ALT_BUZZER_EN, .PB_ALT_BUZZER, .EIGHT_BIT_TIMER_IN, .SIXTEEN_BIT_TIMER_IN, .EXT_INT0, .EXT_INT1);
  tpg_pad tpg_pad_inst(.clk(REF_CLK), .dout({PB_OUT, PA_OUT}), .oe_n({PB_OE_N, PA_OE_N}),
    .ph({PB_PULL_HIGH, PA_PULL_HIGH}), .pl({PB_PULL_LOW, PA_PULL_LOW}), .ext(e), .ext_en(ee), .pad({PB_IN, PA_IN}));
  initial
    forever #12.5 REF_CLK = ~REF_CLK;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
    AVS_ADDRESS <= {idx, 2'h0};
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    @(posedge REF_CLK iff !AVS_WAITREQUEST);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic rc(input logic [6:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic t_reset;
    chk({PA_OE_N, PB_OE_N, PB_PULL_LOW}, 24'hfffffb);
    rc(`TPG_IDX_B_LAT, 8'h00);
    rc(7'h02, 8'h00);
  endtask
  task automatic t_porta;
    bus(1'b1, `TPG_IDX_A_LAT, 8'h5a);
    repeat (3) @(posedge REF_CLK);
    rc(`TPG_IDX_A_PIN, 8'h5a);
    chk(PA_PULL_HIGH, 8'h5a);
    AVS_BYTEENABLE <= 4'h0;
    bus(1'b1, `TPG_IDX_A_DIR, 8'hff);
    AVS_BYTEENABLE <= 4'hf;
    rc(`TPG_IDX_A_DIR, 8'h00);
    bus(1'b1, `TPG_IDX_A_DIR, 8'hff);
    bus(1'b1, `TPG_IDX_A_PIN, 8'h3c);
    rc(`TPG_IDX_A_LAT, 8'h3c);
    bus(1'b1, `TPG_IDX_A_LAT, rd[7:0] | 8'h01);
    chk({PA_OE_N, PA_OUT}, 16'h003d);
    e <= 16'h33a5;
    ee <= 16'hffff;
    bus(1'b1, `TPG_IDX_A_FLT, 8'hff);
    repeat (3) @(posedge REF_CLK);
    rc(`TPG_IDX_A_PIN, 8'ha5);
    chk({PA_OE_N, PA_PULL_HIGH, PA_PULL_LOW}, 24'hff0000);
  endtask
  task automatic t_portb;
    bus(1'b1, `TPG_IDX_B_FLT, 8'hff);
    repeat (5) @(posedge REF_CLK);
    chk({EIGHT_BIT_TIMER_IN, SIXTEEN_BIT_TIMER_IN, EXT_INT0, EXT_INT1}, 4'hf);
    rc(`TPG_IDX_B_PIN, 8'h33);
    e <= 16'h00a5;
    repeat (5) @(posedge REF_CLK);
    chk({EIGHT_BIT_TIMER_IN, SIXTEEN_BIT_TIMER_IN, EXT_INT0, EXT_INT1}, 4'h0);
    bus(1'b1, `TPG_IDX_B_FLT, 8'h00);
    bus(1'b1, `TPG_IDX_B_DIR, 8'hff);
    rc(`TPG_IDX_B_DIR, 8'hfb);
  endtask
  task automatic t_slew;
    bus(1'b1, `TPG_IDX_B_LAT, 8'hc0);
    bus(1'b1, `TPG_IDX_B_LAT, 8'h00);
    repeat (2) @(posedge REF_CLK);
    chk(PB_OUT, 8'h00);
    bus(1'b1, `TPG_IDX_SLEW, 8'hff);
    bus(1'b1, `TPG_IDX_SLEW, 8'hff);
    rc(`TPG_IDX_SLEW, 8'h01);
    bus(1'b1, `TPG_IDX_B_LAT, 8'hc0);
    bus(1'b1, `TPG_IDX_B_LAT, 8'h00);
    repeat (6) @(posedge REF_CLK);
    chk(PB_OUT, 8'hc0);
    repeat (6) @(posedge REF_CLK);
    chk(PB_OUT, 8'h00);
  endtask
  task automatic t_alt;
    bus(1'b1, `TPG_IDX_A_FLT, 8'h00);
    PA_ANALOG_SEL <= 8'hf0;
    PB_ALT_COMPARE_EN <= 1'b1;
    PB_ALT_COMPARE <= 1'b1;
    PB_ALT_BUZZER_EN <= 1'b1;
    PB_ALT_BUZZER <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    chk({PA_OE_N, PA_PULL_HIGH, PA_PULL_LOW}, 24'hf00000);
    chk({PB_OUT, PB_OE_N}, 16'h4804);
    PB_ALT_BUZZER <= 1'b0;
    repeat (5) @(posedge REF_CLK);
    chk(PB_OUT, 8'h48);
    repeat (8) @(posedge REF_CLK);
    chk(PB_OUT, 8'h08);
    PA_ANALOG_SEL <= 8'h00;
    PB_ALT_COMPARE_EN <= 1'b0;
    PB_ALT_COMPARE <= 1'b0;
    PB_ALT_BUZZER_EN <= 1'b0;
    @(posedge REF_CLK);
    chk(PB_OUT, 8'h00);
  endtask
  task automatic give_verdict;
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    t_reset;
    t_porta;
    t_portb;
    t_slew;
    t_alt;
    give_verdict;
  end
  initial
  begin
    repeat (5000) @(posedge REF_CLK);
    err_count++;
    give_verdict;
  end
endmodule
`default_nettype wire
